// ===== logic/tap_debug_port.sv
/*
 * Test access port with debug channel, break point unit and AXI4-Lite
 * register slave.
 * Assumes tck/tms/tdi come from pins, asynchronous to aclk, with tck much
 * slower than aclk; fuses and lock bits are static levels on aclk.
 */
`include "tap_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module tap_debug_port #(
  parameter int ADDR_W = 8,
  parameter logic [31:0] IDCODE = 32'h0000_1001  // Arbitrary value, LSB set
) (
  // Clock, reset, enable
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // AXI4-Lite slave
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Test port pins
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo,
  output logic tdo_oe,
  output logic pullup_en,
  // Fuses and lock bits
  input wire logic test_port_enable_fuse,
  input wire logic debug_enable_fuse,
  input wire logic lock_bit_one,
  input wire logic lock_bit_two,
  // CPU side
  output logic [15:0] cpu_instr,
  output logic cpu_instr_valid,
  input wire logic [15:0] pc,
  input wire logic pc_valid,
  input wire logic flow_change,
  input wire logic [15:0] daddr,
  input wire logic daddr_valid,
  output logic break_req
);
  ////////////////////////////////////////////////////////////////////////
  // Standard state graph
  function automatic tap_pkg::tap_state_t tap_next(tap_pkg::tap_state_t s,
                                                   logic m);
    case (s)
      tap_pkg::S_TLR: tap_next = m ? tap_pkg::S_TLR : tap_pkg::S_RTI;
      tap_pkg::S_RTI: tap_next = m ? tap_pkg::S_SELDR : tap_pkg::S_RTI;
      tap_pkg::S_SELDR: tap_next = m ? tap_pkg::S_SELIR : tap_pkg::S_CAPDR;
      tap_pkg::S_CAPDR: tap_next = m ? tap_pkg::S_EX1DR : tap_pkg::S_SHDR;
      tap_pkg::S_SHDR: tap_next = m ? tap_pkg::S_EX1DR : tap_pkg::S_SHDR;
      tap_pkg::S_EX1DR: tap_next = m ? tap_pkg::S_UPDR : tap_pkg::S_PDR;
      tap_pkg::S_PDR: tap_next = m ? tap_pkg::S_EX2DR : tap_pkg::S_PDR;
      tap_pkg::S_EX2DR: tap_next = m ? tap_pkg::S_UPDR : tap_pkg::S_SHDR;
      tap_pkg::S_UPDR: tap_next = m ? tap_pkg::S_SELDR : tap_pkg::S_RTI;
      tap_pkg::S_SELIR: tap_next = m ? tap_pkg::S_TLR : tap_pkg::S_CAPIR;
      tap_pkg::S_CAPIR: tap_next = m ? tap_pkg::S_EX1IR : tap_pkg::S_SHIR;
      tap_pkg::S_SHIR: tap_next = m ? tap_pkg::S_EX1IR : tap_pkg::S_SHIR;
      tap_pkg::S_EX1IR: tap_next = m ? tap_pkg::S_UPIR : tap_pkg::S_PIR;
      tap_pkg::S_PIR: tap_next = m ? tap_pkg::S_EX2IR : tap_pkg::S_PIR;
      tap_pkg::S_EX2IR: tap_next = m ? tap_pkg::S_UPIR : tap_pkg::S_SHIR;
      tap_pkg::S_UPIR: tap_next = m ? tap_pkg::S_SELDR : tap_pkg::S_RTI;
      default: tap_next = tap_pkg::S_TLR;
    endcase
  endfunction : tap_next

  // Word index of a mapped offset, top bit flags a hit
  function automatic logic [3:0] reg_idx(logic [ADDR_W-1:0] a);
    case (a[7:0])
      `A_OCDR: reg_idx = 4'h8;
      `A_STAT: reg_idx = 4'h9;
      `A_BPCTL: reg_idx = 4'hA;
      `A_BP0: reg_idx = 4'hB;
      `A_BP1: reg_idx = 4'hC;
      `A_BP2: reg_idx = 4'hD;
      `A_BP3: reg_idx = 4'hE;
      default: reg_idx = 4'h0;
    endcase
  endfunction : reg_idx

  function automatic logic [31:0] merge(logic [31:0] o, logic [31:0] n,
                                        logic [3:0] s);
    for (int b = 0; b < 4; b++) begin
      o[b*8 +: 8] = s[b] ? n[b*8 +: 8] : o[b*8 +: 8];
    end
    merge = o;
  endfunction : merge

  ////////////////////////////////////////////////////////////////////////
  logic [2:0] tck_s, tms_s, tdi_s;
  logic tck_f_q, tck_f_d, tck_rise, tck_fall, dbg_q, dbg_d, pu_q;
  assign tck_f_d = (tck_s[1] == tck_s[2]) ? tck_s[2] : tck_f_q;
  assign tck_rise = tck_f_d & ~tck_f_q;
  assign tck_fall = ~tck_f_d & tck_f_q;
  // Debug gate from fuse and locks
  assign dbg_d = debug_enable_fuse & ~lock_bit_one & ~lock_bit_two;

  ////////////////////////////////////////////////////////////////////////
  tap_pkg::tap_state_t st_q, st_d;
  logic [`IR_W-1:0] ir_q, ir_d, irs_q, irs_d, sel;
  logic [`DR_W-1:0] dr_q, dr_d;
  logic [4:0] msb;
  logic tdo_q, tdo_d, oe_q, oe_d, cv_q, cv_d, dclr;
  logic [`CPU_W-1:0] ci_q, ci_d;
  logic [7:0] ocdr_q, ocdr_d;
  logic dirty_q, dirty_d;

  // Effective instruction; debug paths fall back to bypass
  always_comb begin
    case (ir_q)
      `I_IDCODE: sel = `I_IDCODE;
      `I_CPU, `I_COMM: sel = dbg_q ? ir_q : `I_BYPASS;
      default: sel = `I_BYPASS;
    endcase
    case (sel)
      `I_IDCODE: msb = `MSB_ID;
      `I_CPU: msb = `MSB_CPU;
      `I_COMM: msb = `MSB_COMM;
      default: msb = `MSB_BYP;
    endcase
  end

  always_comb begin
    st_d = st_q;
    ir_d = ir_q;
    irs_d = irs_q;
    dr_d = dr_q;
    tdo_d = tdo_q;
    oe_d = oe_q;
    ci_d = ci_q;
    cv_d = 1'b0;
    dclr = 1'b0;
    // Fuse off holds the controller in reset
    if (!test_port_enable_fuse) begin
      st_d = tap_pkg::S_TLR;
      oe_d = 1'b0;
    end else if (tck_rise) begin
      st_d = tap_next(st_q, tms_s[2]);
      case (st_q)
        tap_pkg::S_CAPIR: irs_d = `IR_CAPT;
        tap_pkg::S_SHIR: irs_d = {tdi_s[2], irs_q[`IR_W-1:1]};
        tap_pkg::S_UPIR: ir_d = irs_q;
        tap_pkg::S_CAPDR: begin
          case (sel)
            `I_IDCODE: dr_d = IDCODE;
            `I_COMM: dr_d = {{(`DR_W-8){1'b0}}, dirty_q, ocdr_q[6:0]};
            default: dr_d = '0;
          endcase
        end
        tap_pkg::S_SHDR: begin
          dr_d = dr_q >> 1;
          dr_d[msb] = tdi_s[2];
        end
        tap_pkg::S_UPDR: begin
          if (sel == `I_CPU) begin
            ci_d = dr_q[`CPU_W-1:0];
            cv_d = 1'b1;
          end
          dclr = (sel == `I_COMM);
        end
        default: ;
      endcase
    end else if (tck_fall) begin
      oe_d = (st_q == tap_pkg::S_SHIR) || (st_q == tap_pkg::S_SHDR);
      tdo_d = (st_q == tap_pkg::S_SHIR) ? irs_q[0] : dr_q[0];
    end
    if (st_d == tap_pkg::S_TLR) begin
      ir_d = `I_IDCODE;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  logic [ADDR_W-1:0] awa_q, awa_d;
  logic [31:0] wd_q, wd_d, rd_q, rd_d;
  logic [3:0] ws_q, ws_d, widx;
  logic aw_q, aw_d, w_q, w_d, awr_q, awr_d, wr_q, wr_d, bv_q, bv_d, arr_q;
  logic arr_d, rv_q, rv_d;
  logic [1:0] br_q, br_d, rr_q, rr_d;
  tap_pkg::bp_ctl_t bc_q, bc_d;
  logic [`BP_W-1:0] bp_q [`BP_N];
  logic [`BP_W-1:0] bp_d [`BP_N];
  logic [3:0] ri;
  logic [31:0] bc_m, bp_m;
  // Byte-lane merges of the held write data into old contents
  assign bc_m = merge(32'(bc_q), wd_q, ws_q);
  assign bp_m = merge(32'(bp_q[widx[1:0] + 2'h1]), wd_q, ws_q);

  always_comb begin
    aw_d = aw_q;
    awa_d = awa_q;
    w_d = w_q;
    wd_d = wd_q;
    ws_d = ws_q;
    bv_d = bv_q;
    br_d = br_q;
    rv_d = rv_q;
    rd_d = rd_q;
    rr_d = rr_q;
    ocdr_d = ocdr_q;
    bc_d = bc_q;
    bp_d = bp_q;
    dirty_d = dirty_q & ~dclr;
    widx = reg_idx(awa_q);
    ri = reg_idx(araddr);
    if (awvalid && awr_q) begin
      aw_d = 1'b1;
      awa_d = awaddr;
    end
    if (wvalid && wr_q) begin
      w_d = 1'b1;
      wd_d = wdata;
      ws_d = wstrb;
    end
    if (bv_q && bready) begin
      bv_d = 1'b0;
    end
    if (aw_q && w_q && !bv_q) begin
      aw_d = 1'b0;
      w_d = 1'b0;
      bv_d = 1'b1;
      br_d = widx[3] ? `R_OKAY : `R_DECERR;
      case (widx)
        4'h8: if (ws_q[0]) begin
          ocdr_d = wd_q[7:0];
          // CPU write marks data waiting; set beats clear
          dirty_d = 1'b1;
        end
        4'hA: bc_d = tap_pkg::bp_ctl_t'(bc_m[$bits(tap_pkg::bp_ctl_t)-1:0]);
        4'hB, 4'hC, 4'hD, 4'hE:
          bp_d[widx[1:0] + 2'h1] = bp_m[`BP_W-1:0];
        default: ;
      endcase
    end
    awr_d = ~aw_d & ~bv_d;
    wr_d = ~w_d & ~bv_d;
    if (rv_q && rready) begin
      rv_d = 1'b0;
    end
    if (arvalid && arr_q) begin
      rv_d = 1'b1;
      rr_d = ri[3] ? `R_OKAY : `R_DECERR;
      case (ri)
        4'h8: rd_d = {24'h0, dirty_q, ocdr_q[6:0]};
        4'h9: rd_d = {11'h0, dbg_q, ir_q, st_q};
        4'hA: rd_d = 32'(bc_q);
        4'hB, 4'hC, 4'hD, 4'hE: rd_d = 32'(bp_q[ri[1:0] + 2'h1]);
        default: rd_d = 32'h0;
      endcase
    end
    arr_d = ~rv_d;
  end

  ////////////////////////////////////////////////////////////////////////
  logic [`BP_N-1:0] hit;
  logic brk_q, brk_d;
  // Two program and two combined break points
  for (genvar i = 0; i < `BP_N; i++) begin : g_bp
    logic dsel;
    logic [15:0] tgt, m;
    logic tv;
    assign dsel = (i >= 2) && bp_q[i][`BP_DSEL];
    assign tgt = dsel ? daddr : pc;
    assign tv = dsel ? daddr_valid : pc_valid;
    assign m = (i == 2 && bc_q.mask_mode) ? ~bp_q[3][15:0] : 16'hFFFF;
    assign hit[i] = bc_q.en[i] && tv && ((tgt ^ bp_q[i][15:0]) & m) == 16'h0
                    && !(i == 3 && bc_q.mask_mode);
  end
  assign brk_d = dbg_q & ((|hit) | (bc_q.flow & flow_change)
                          | (bc_q.step & pc_valid));

  ////////////////////////////////////////////////////////////////////////
  // The bus reset, TMS and a cleared port fuse reset the controller
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {tck_s, tms_s, tdi_s} <= '0;
      tck_f_q <= 1'b0;
      dbg_q <= 1'b0;
      pu_q <= 1'b0;
      st_q <= tap_pkg::S_TLR;
      ir_q <= `I_IDCODE;
      irs_q <= '0;
      dr_q <= '0;
      {tdo_q, oe_q, cv_q, dirty_q, brk_q} <= '0;
      ci_q <= '0;
      ocdr_q <= '0;
      {aw_q, w_q, awr_q, wr_q, bv_q, arr_q, rv_q} <= '0;
      {awa_q, wd_q, ws_q, br_q, rd_q, rr_q} <= '0;
      bc_q <= '0;
      for (int i = 0; i < `BP_N; i++) begin
        bp_q[i] <= '0;
      end
    end else if (ce) begin
      tck_s <= {tck_s[1:0], tck};
      tms_s <= {tms_s[1:0], tms};
      tdi_s <= {tdi_s[1:0], tdi};
      tck_f_q <= tck_f_d;
      dbg_q <= dbg_d;
      pu_q <= test_port_enable_fuse;
      st_q <= st_d;
      {ir_q, irs_q, dr_q} <= {ir_d, irs_d, dr_d};
      {tdo_q, oe_q, cv_q, ci_q} <= {tdo_d, oe_d, cv_d, ci_d};
      {ocdr_q, dirty_q, brk_q} <= {ocdr_d, dirty_d, brk_d};
      {aw_q, w_q, awr_q, wr_q, bv_q} <= {aw_d, w_d, awr_d, wr_d, bv_d};
      {arr_q, rv_q, awa_q, wd_q, ws_q} <= {arr_d, rv_d, awa_d, wd_d, ws_d};
      {br_q, rd_q, rr_q, bc_q} <= {br_d, rd_d, rr_d, bc_d};
      bp_q <= bp_d;
    end
  end

  assign {awready, wready, bvalid, bresp} = {awr_q, wr_q, bv_q, br_q};
  assign {arready, rvalid, rdata, rresp} = {arr_q, rv_q, rd_q, rr_q};
  assign {tdo, tdo_oe, pullup_en} = {tdo_q, oe_q, pu_q};
  assign {cpu_instr, cpu_instr_valid, break_req} = {ci_q, cv_q, brk_q};

  ////////////////////////////////////////////////////////////////////////
  logic [2:0] ones_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ones_q <= '0;
    end else if (ce && tck_rise) begin
      ones_q <= !tms_s[2] ? 3'h0 : (ones_q == `TMS_RST_N) ? ones_q
                : ones_q + 3'h1;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_reset_state: assert property ($rose(aresetn) |-> st_q == tap_pkg::S_TLR)
    else $error("not in reset state after reset");
  a_shift_hold: assert property (ce && tck_rise && test_port_enable_fuse
    && st_q == tap_pkg::S_SHIR && !tms_s[2] |=> st_q == tap_pkg::S_SHIR)
    else $error("left shift-ir with tms low");
  a_ir_lsb_first: assert property (ce && tck_rise && test_port_enable_fuse
    && st_q == tap_pkg::S_SHIR |=> irs_q[`IR_W-1] == $past(tdi_s[2]))
    else $error("tdi not in instruction msb");
  a_ir_capture: assert property (ce && tck_rise && test_port_enable_fuse
    && st_q == tap_pkg::S_CAPIR |=> irs_q == `IR_CAPT)
    else $error("capture-ir value wrong");
  a_ir_update: assert property ($changed(ir_q) |->
    $past(st_q) == tap_pkg::S_UPIR || st_q == tap_pkg::S_TLR)
    else $error("instruction changed outside update");
  a_bypass_zero: assert property (ce && tck_rise && test_port_enable_fuse
    && st_q == tap_pkg::S_CAPDR && sel == `I_BYPASS |=> dr_q[0] == 1'b0)
    else $error("bypass not cleared");
  a_five_ones: assert property (ones_q == `TMS_RST_N && !tck_rise
    |-> st_q == tap_pkg::S_TLR)
    else $error("five tms high did not reset");
  a_fuse_hold: assert property (ce && !test_port_enable_fuse
    |=> st_q == tap_pkg::S_TLR ##0 !tdo_oe)
    else $error("controller not held by fuse");
  a_debug_lock: assert property ((lock_bit_one || lock_bit_two)
    |-> ##2 (!cpu_instr_valid && !break_req))
    else $error("debug active while locked");
  a_default_id: assert property (st_q == tap_pkg::S_TLR |-> ir_q == `I_IDCODE)
    else $error("identification not default");
  a_cpu_update: assert property ($rose(cpu_instr_valid)
    |-> $past(st_q) == tap_pkg::S_UPDR)
    else $error("cpu word outside update-dr");

  c_ir_update: cover property (st_q == tap_pkg::S_UPIR ##1 st_q == tap_pkg::S_RTI);
  c_cpu_word: cover property (cpu_instr_valid);
  c_break: cover property (break_req);
  c_bus_write: cover property (bvalid && bready && bresp == `R_OKAY);
endmodule : tap_debug_port
`default_nettype wire

// ===== logic/tap_pkg.sv
/*
 * Types of the test port and debug block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package tap_pkg;
  typedef enum logic [15:0] {
    S_TLR = 16'h0001, S_RTI = 16'h0002, S_SELDR = 16'h0004,
    S_CAPDR = 16'h0008, S_SHDR = 16'h0010, S_EX1DR = 16'h0020,
    S_PDR = 16'h0040, S_EX2DR = 16'h0080, S_UPDR = 16'h0100,
    S_SELIR = 16'h0200, S_CAPIR = 16'h0400, S_SHIR = 16'h0800,
    S_EX1IR = 16'h1000, S_PIR = 16'h2000, S_EX2IR = 16'h4000,
    S_UPIR = 16'h8000
  } tap_state_t;
  typedef struct packed {
    logic mask_mode;
    logic step;
    logic flow;
    logic [3:0] en;
  } bp_ctl_t;
endpackage : tap_pkg

// ===== logic/tap_regs.svh
/*
 * Constants of the test port and debug block: instruction codes, shift
 * lengths, bus offsets and response codes.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef TAP_REGS_SVH
`define TAP_REGS_SVH
`define IR_W 4
`define IR_CAPT 4'h1
`define I_IDCODE 4'h1
`define I_BYPASS 4'hF
`define I_CPU 4'h8
`define I_COMM 4'h9
`define DR_W 32
`define MSB_ID 5'h1F
`define MSB_BYP 5'h00
`define MSB_CPU 5'h0F
`define MSB_COMM 5'h07
`define CPU_W 16
`define BP_N 4
`define BP_W 17
`define BP_DSEL 16
`define A_OCDR 8'h00
`define A_STAT 8'h04
`define A_BPCTL 8'h08
`define A_BP0 8'h0C
`define A_BP1 8'h10
`define A_BP2 8'h14
`define A_BP3 8'h18
`define R_OKAY 2'h0
`define R_DECERR 2'h3
`define TMS_RST_N 3'h5
`endif

// ===== testbench/jtag_tap_and_debug_port_tb.sv
/*
 * Self-checking bench of the test port: bus tasks, scans through the
 * controller model, break point table.
 * Assumes the design and its package and constants header.
 */
`timescale 1ns/1ps
`default_nettype none
`include "tap_regs.svh"
module jtag_tap_and_debug_port_tb;
  // Arbitrary value, LSB set
  localparam logic [31:0] ID = 32'h1357_9BDF;
  logic aclk;
  logic aresetn = 1'b0, ce = 1'b1;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0, rdata, cap, rdv;
  logic [3:0] wstrb = 4'hF;
  logic awready, wready, bvalid, arready, rvalid, tck, tms, tdi, tdo, tdo_oe, pullup_en;
  logic [1:0] bresp, rresp, rsp;
  logic port_fuse = 1'b1, dbg_fuse = 1'b1, lock_bit_one = 1'b0, lock_bit_two = 1'b0;
  logic [15:0] cpu_instr, pc = 16'h0, daddr = 16'h0;
  logic cpu_instr_valid, break_req, pc_valid = 1'b0, flow_change = 1'b0, daddr_valid = 1'b0;
  int miscompares = 0, check_count = 0, cycles = 0, pulses = 0;

  tap_debug_port #(.ADDR_W(8), .IDCODE(ID)) u_dut (
    .aclk(aclk), .aresetn(aresetn), .ce(ce),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe), .pullup_en(pullup_en),
    .test_port_enable_fuse(port_fuse), .debug_enable_fuse(dbg_fuse),
    .lock_bit_one(lock_bit_one), .lock_bit_two(lock_bit_two),
    .cpu_instr(cpu_instr), .cpu_instr_valid(cpu_instr_valid), .pc(pc), .pc_valid(pc_valid),
    .flow_change(flow_change), .daddr(daddr), .daddr_valid(daddr_valid),
    .break_req(break_req)
  );
  // Released output shows the inverse, so a late enable gives a bad bit
  wire logic tdo_line;
  assign tdo_line = tdo_oe ? tdo : ~tdo;
  tap_host_model u_host (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo_line));

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cpu_instr_valid === 1'b1) pulses <= pulses + 1;
    if (cycles == 20000) begin
      miscompares++;
      tally_and_finish();
    end
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : rd
  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
    rd(a, rdv, rsp);
    chk(nm, e, rdv);
  endtask : rdc
  function automatic logic [31:0] st(input logic d, input logic [3:0] i, input logic [15:0] s);
    st = {11'h000, d, i, s};
  endfunction : st
  task automatic bp(input logic [7:0] c, input logic [15:0] p, input logic pv,
                    input logic fc, input logic [15:0] da, input logic dv, input logic e);
    wr(`A_BPCTL, {24'h000000, c}, rsp);
    pc <= p;
    pc_valid <= pv;
    flow_change <= fc;
    daddr <= da;
    daddr_valid <= dv;
    repeat (4) @(posedge aclk);
    chk("break_req", {31'h0, e}, {31'h0, break_req});
    pc_valid <= 1'b0;
    flow_change <= 1'b0;
    daddr_valid <= 1'b0;
    repeat (4) @(posedge aclk);
  endtask : bp
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (10) @(posedge aclk);
    rdc("status", `A_STAT, st(1'b1, `I_IDCODE, tap_pkg::S_TLR));
    chk("pullup_en", 32'h1, {31'h0, pullup_en});
    rd(8'h1C, rdv, rsp);
    chk("unmapped rresp", {30'h0, `R_DECERR}, {30'h0, rsp});
    wr(8'h1C, 32'hFFFF_FFFF, rsp);
    chk("unmapped bresp", {30'h0, `R_DECERR}, {30'h0, rsp});
    u_host.walk(8'h00, 1);
    u_host.scan(1'b0, 32'h0, 32, cap);
    chk("idcode", ID, cap);
    u_host.finish(1'b1);
    u_host.scan(1'b1, {28'h0, `I_BYPASS}, 4, cap);
    chk("ir capture", {28'h0, `IR_CAPT}, {28'h0, cap[3:0]});
    rdc("status exit1-ir", `A_STAT, st(1'b1, `I_IDCODE, tap_pkg::S_EX1IR));
    u_host.finish(1'b0);
    u_host.scan(1'b0, 32'hB, 4, cap);
    chk("bypass", 32'h6, {28'h0, cap[3:0]});
    rdc("status exit1-dr", `A_STAT, st(1'b1, `I_BYPASS, tap_pkg::S_EX1DR));
    u_host.finish(1'b1);
    u_host.walk(8'h01, 3);
    u_host.walk(8'h0F, 4);
    rdc("status four high", `A_STAT, st(1'b1, `I_BYPASS, tap_pkg::S_SELIR));
    u_host.walk(8'h01, 1);
    rdc("status five high", `A_STAT, st(1'b1, `I_IDCODE, tap_pkg::S_TLR));
    u_host.walk(8'h00, 1);
    u_host.scan(1'b1, {28'h0, `I_CPU}, 4, cap);
    u_host.finish(1'b1);
    u_host.scan(1'b0, 32'hA55A, 16, cap);
    repeat (8) @(posedge aclk);
    chk("early instr", 32'h0, pulses);
    u_host.finish(1'b1);
    repeat (8) @(posedge aclk);
    chk("cpu_instr", 32'hA55A, {16'h0, cpu_instr});
    chk("instr pulses", 32'h1, pulses);
    wr(`A_OCDR, 32'h5A, rsp);
    u_host.scan(1'b1, {28'h0, `I_COMM}, 4, cap);
    u_host.finish(1'b1);
    u_host.scan(1'b0, 32'h0, 8, cap);
    chk("comm capture", 32'hDA, {24'h0, cap[7:0]});
    u_host.finish(1'b1);
    rdc("ocdr", `A_OCDR, 32'h5A);
    wstrb <= 4'hE;
    wr(`A_OCDR, 32'h77, rsp);
    wstrb <= 4'hF;
    rdc("ocdr strobe", `A_OCDR, 32'h5A);
    for (int k = 3; k >= 0; k--) begin
      @(posedge aclk);
      lock_bit_one <= k[0];
      lock_bit_two <= k[1];
      repeat (4) @(posedge aclk);
      rdc("debug gate", `A_STAT, st(k == 0, `I_COMM, tap_pkg::S_RTI));
      if (k == 1) begin
        u_host.scan(1'b0, 32'h1, 2, cap);
        chk("locked bypass", 32'h2, {30'h0, cap[1:0]});
        u_host.finish(1'b1);
      end
    end
    dbg_fuse <= 1'b0;
    repeat (4) @(posedge aclk);
    rdc("debug fuse", `A_STAT, st(1'b0, `I_COMM, tap_pkg::S_RTI));
    dbg_fuse <= 1'b1;
    @(posedge aclk);
    ce <= 1'b0;
    u_host.walk(8'h01, 3);
    @(posedge aclk);
    ce <= 1'b1;
    rdc("ce freeze", `A_STAT, st(1'b1, `I_COMM, tap_pkg::S_RTI));
    wr(`A_BP0, 32'h0100, rsp);
    wr(`A_BP1, 32'h0200, rsp);
    wr(`A_BP2, 32'h1_0300, rsp);
    wr(`A_BP3, 32'h000F, rsp);
    bp(8'h01, 16'h0100, 1'b1, 1'b0, 16'h0, 1'b0, 1'b1);
    bp(8'h01, 16'h0101, 1'b1, 1'b0, 16'h0, 1'b0, 1'b0);
    bp(8'h02, 16'h0200, 1'b1, 1'b0, 16'h0, 1'b0, 1'b1);
    bp(8'h04, 16'h0300, 1'b1, 1'b0, 16'h0, 1'b0, 1'b0);
    bp(8'h04, 16'h0, 1'b0, 1'b0, 16'h030A, 1'b1, 1'b0);
    bp(8'h44, 16'h0, 1'b0, 1'b0, 16'h030A, 1'b1, 1'b1);
    bp(8'h4C, 16'h000F, 1'b1, 1'b0, 16'h0, 1'b0, 1'b0);
    bp(8'h08, 16'h000F, 1'b1, 1'b0, 16'h0, 1'b0, 1'b1);
    bp(8'h10, 16'h0, 1'b0, 1'b1, 16'h0, 1'b0, 1'b1);
    bp(8'h20, 16'h1234, 1'b1, 1'b0, 16'h0, 1'b0, 1'b1);
    bp(8'h00, 16'h0100, 1'b1, 1'b1, 16'h0300, 1'b1, 1'b0);
    @(posedge aclk);
    port_fuse <= 1'b0;
    repeat (4) @(posedge aclk);
    u_host.walk(8'h00, 2);
    rd(`A_STAT, rdv, rsp);
    chk("fuse off", {12'h0, `I_IDCODE, tap_pkg::S_TLR}, {12'h0, rdv[19:0]});
    chk("pullup off", 32'h0, {31'h0, pullup_en});
    tally_and_finish();
  end
endmodule : jtag_tap_and_debug_port_tb
`default_nettype wire

// ===== testbench/tap_host_model.sv
/*
 * External test controller model: drives the link clock, mode select and
 * data in, and takes the serial output back.
 * Assumes a caller that starts each frame from Run-Test/Idle or Update.
 */
`timescale 1ns/1ps
`default_nettype none
module tap_host_model (
  // Test port pins
  output logic tck,
  output logic tms,
  output logic tdi,
  input wire logic tdo
);
  // system reset line stays on the board side, not driven here
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////
  // output taken before rise
  task automatic bit_io(input logic m, input logic d, output logic o);
    tms = m;
    tdi = d;
    #80;
    o = tdo;
    tck = 1'b1;
    #80;
    tck = 1'b0;
  endtask : bit_io
  task automatic walk(input logic [7:0] seq, input int n);
    logic o;
    #2.5;
    for (int i = 0; i < n; i++) begin
      bit_io(seq[i], ~tdi, o);
    end
  endtask : walk
  // shift LSB first, exit on last
  task automatic scan(input logic ir, input logic [31:0] d, input int n,
                      output logic [31:0] cap);
    logic o;
    cap = 32'h0;
    if (ir) walk(8'h03, 4);
    else walk(8'h01, 3);
    for (int i = 0; i < n; i++) begin
      bit_io(i == n - 1, d[i], o);
      cap[i] = o;
    end
  endtask : scan
  task automatic finish(input logic idle);
    walk(8'h01, idle ? 2 : 1);
  endtask : finish
endmodule : tap_host_model
`default_nettype wire
